// [include/scp_cfg.svh]
// Constants of the system clock prescaler and trim block.
// Assumes a 32-bit APB slave where each register takes one aligned word.
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH
// ---------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ---------------------------------------------------------------
`define SCP_IDX_PRESCALE 10'h061
`define SCP_IDX_TRIM 10'h066
`define SCP_IDX_EXTCLK 10'h070
// ---------------------------------------------------------------
// Field positions and values.
// ---------------------------------------------------------------
`define SCP_UNLOCK_BIT 7
`define SCP_UNLOCK_VAL 8'h80
`define SCP_EXT_BIT 0
`define SCP_SEL_RST 4'h0
`define SCP_SEL_DIV8 4'h3
`define SCP_CODE_MAX 4'h8
`define SCP_TRIM_RST 8'h00
// ---------------------------------------------------------------
// Timing counts in pclk cycles.
// ---------------------------------------------------------------
`define SCP_UNLOCK_CYCLES 3'd4
`define SCP_INIT_LOAD 2'd2
`endif

// [include/scp_pkg.sv]
// Types shared by the system clock prescaler and trim block.
// Assumes the constants of scp_cfg.svh are included where needed.
package scp_pkg;
	// One-hot state of the prescale change unlock window.
	typedef enum logic [1:0] {
		SCP_LOCKED = 2'b01,
		SCP_OPEN = 2'b10
	} scp_state_t;
endpackage

// [design/scp_prescaler.sv]
// System clock prescaler, clock output control and RC trim register.
// Assumes one 125 MHz pclk standing in for the undivided master clock;
// fuses and the factory trim value arrive as static pins.
// Behaviour
// [RL1] System clock at least four times timer oscillator
// [RL2] Enable bit selects external clock on timer pin
// [RL3] Clock-out fuse drives system clock on pin
// [RL4] Clock output carries the divided clock; at factor 1 the pin toggles at half the master rate instead
// [RL5] One divider slows cpu, flash, io clocks
// [RL6] Division change never makes a short period
// [RL7] New rate active after old then new period
// [RL8] Divider counts at master rate, state unreadable
// [RL9] Unlock is a write of exactly 0x80
// [RL10] Select written within four cycles after unlock
// [RL11] Software masks interrupts during the sequence
// [RL12] Unlock bit updated only when others zero
// [RL13] Unlock closes after four cycles or select write
// [RL14] Repeat unlock neither restarts nor clears window
// [RL15] Reset select is 0000, or 0011 with fuse
// [RL16] Any code writable after reset
// [RL17] Codes 0..8 divide by 1..256
// [RL18] Trim loads factory value at reset
// [RL19] Trim top bit selects oscillator range
// [RL20] Lower trim bits tune monotonically
// [RL21] Software keeps trim below 8.8 MHz for writes
// [RL22] Bits 6..4 read zero; reserved codes divide by 256
`timescale 1ns/1ps
`include "scp_cfg.svh"

module scp_prescaler
	import scp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic clock_out_fuse,
	input wire logic divide_by_eight_fuse,
	input wire logic [7:0] rc_trim_factory,
	output logic cpu_clock_en,
	output logic flash_clock_en,
	output logic io_clock_en,
	output logic clock_out_pin,
	output logic clock_out_drive,
	output logic ext_clock_input_enable,
	output logic trim_range_bit,
	output logic [6:0] trim_tune
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------

	// Terminal count of the divider for a select code.
	function automatic logic [7:0] lim_of(input logic [3:0] code);
		logic [7:0] l;
		l = 8'hff;
		if (code <= `SCP_CODE_MAX) begin
			l = 8'((9'h001 << code) - 9'h001); // RL17
		end
		return l; // RL22
	endfunction

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------

	logic cof_s1, cof_s2; // Clock-out fuse synchroniser.
	logic d8f_s1, d8f_s2; // Divide-by-eight fuse synchroniser.
	logic [7:0] tf_s1, tf_s2; // Factory trim synchroniser.
	logic [1:0] init_cnt; // Counts edges after reset release.
	scp_state_t ustate; // Unlock window state.
	logic [2:0] ucnt; // Cycles left in the unlock window.
	logic [3:0] sel; // Stored division select code.
	logic [3:0] eff_code; // Code the divider actually uses.
	logic pending; // A new code waits for the period end.
	logic [7:0] cnt; // Divider count, never visible on the bus.
	logic [7:0] rc_trim; // Oscillator trim value.
	logic ext_en; // External clock enable bit.
	logic [7:0] lim;
	logic tick;
	logic [7:0] next_cnt;
	logic acc; // Access phase of a transfer.
	logic wr_pre, wr_trim, wr_ext;
	logic [9:0] idx;
	logic [7:0] wb;

	assign idx = paddr[11:2];
	assign wb = pwdata[7:0];
	assign acc = psel && penable && pready;
	assign wr_pre = acc && pwrite && idx == `SCP_IDX_PRESCALE;
	assign wr_trim = acc && pwrite && idx == `SCP_IDX_TRIM;
	assign wr_ext = acc && pwrite && idx == `SCP_IDX_EXTCLK;
	assign lim = lim_of(eff_code);
	assign tick = cnt == lim;
	assign next_cnt = tick ? 8'h00 : 8'(cnt + 8'h01);

	// ---------------------------------------------------------------
	// Synchronisers
	// ---------------------------------------------------------------

	// Fuse and factory pins are outside the clock domain.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cof_s1 <= 1'b0;
			cof_s2 <= 1'b0;
			d8f_s1 <= 1'b0;
			d8f_s2 <= 1'b0;
			tf_s1 <= `SCP_TRIM_RST;
			tf_s2 <= `SCP_TRIM_RST;
		end else begin
			cof_s1 <= clock_out_fuse;
			cof_s2 <= cof_s1;
			d8f_s1 <= divide_by_eight_fuse;
			d8f_s2 <= d8f_s1;
			tf_s1 <= rc_trim_factory;
			tf_s2 <= tf_s1;
		end
	end

	// Straps are caught once the synchronisers have filled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_cnt <= 2'd0;
		end else if (init_cnt != 2'd3) begin
			init_cnt <= 2'(init_cnt + 2'd1);
		end
	end

	// ---------------------------------------------------------------
	// Unlock window
	// ---------------------------------------------------------------

	// Only an exact 0x80 opens the window; a repeat leaves it alone.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ustate <= SCP_LOCKED;
			ucnt <= 3'd0;
		end else begin
			case (ustate)
				SCP_LOCKED: begin
					if (wr_pre && wb == `SCP_UNLOCK_VAL) begin // RL12
						ustate <= SCP_OPEN;
						ucnt <= 3'(`SCP_UNLOCK_CYCLES - 3'd1);
					end
				end
				SCP_OPEN: begin
					// A select write closes the window early.
					if (wr_pre && !wb[`SCP_UNLOCK_BIT]) begin // RL13
						ustate <= SCP_LOCKED;
					end else if (ucnt == 3'd0) begin // RL13
						ustate <= SCP_LOCKED;
					end else begin
						ucnt <= 3'(ucnt - 3'd1); // RL14
					end
				end
				default: begin
					ustate <= SCP_LOCKED;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Division select
	// ---------------------------------------------------------------

	// The select field loads from the fuse, then only via the window.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel <= `SCP_SEL_RST;
		end else if (init_cnt == `SCP_INIT_LOAD) begin
			sel <= d8f_s2 ? `SCP_SEL_DIV8 : `SCP_SEL_RST; // RL15
		end else if (wr_pre && ustate == SCP_OPEN && !wb[`SCP_UNLOCK_BIT]) begin
			sel <= wb[3:0]; // RL16
		end
	end

	// A new code waits for the running period to end, so the
	// switch period is never shorter than old or new one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eff_code <= `SCP_SEL_RST;
			pending <= 1'b0;
		end else begin
			if (tick && pending) begin
				eff_code <= sel; // RL6 RL7
			end
			if (sel != eff_code && !(tick && pending)) begin
				pending <= 1'b1;
			end else if (tick) begin
				pending <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Divider
	// ---------------------------------------------------------------

	// Counts at the master rate; its state is not on the bus.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
		end else begin
			cnt <= next_cnt; // RL8
		end
	end

	// One enable pulse per divided period for all three domains.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_clock_en <= 1'b0;
			flash_clock_en <= 1'b0;
			io_clock_en <= 1'b0;
		end else begin
			cpu_clock_en <= tick; // RL5
			flash_clock_en <= tick;
			io_clock_en <= tick;
		end
	end

	// Pin image of the divided clock; high for the first half.
	// At factor 1 it toggles, so it shows half the master rate.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_out_pin <= 1'b0;
		end else if (lim == 8'h00) begin
			clock_out_pin <= !clock_out_pin;
		end else begin
			clock_out_pin <= next_cnt <= (lim >> 1); // RL4
		end
	end

	// The fuse overrides the pin's normal function.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_out_drive <= 1'b0;
		end else begin
			clock_out_drive <= cof_s2; // RL3
		end
	end

	// ---------------------------------------------------------------
	// Trim and external clock registers
	// ---------------------------------------------------------------

	// Factory value loads after reset; software may retune.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_trim <= `SCP_TRIM_RST;
		end else if (init_cnt == `SCP_INIT_LOAD) begin
			rc_trim <= tf_s2; // RL18
		end else if (wr_trim) begin
			rc_trim <= wb;
		end
	end

	assign trim_range_bit = rc_trim[7]; // RL19
	assign trim_tune = rc_trim[6:0]; // RL20

	// Selects an external clock on the timer oscillator pin.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_en <= 1'b0;
		end else if (wr_ext) begin
			ext_en <= wb[`SCP_EXT_BIT]; // RL2
		end
	end

	assign ext_clock_input_enable = ext_en;

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------

	// Answer is prepared in setup, so access needs no wait.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable) begin
				case (idx)
					`SCP_IDX_PRESCALE: begin
						prdata[7] <= ustate == SCP_OPEN; // RL22
						prdata[3:0] <= sel;
					end
					`SCP_IDX_TRIM: begin
						prdata[7:0] <= rc_trim;
					end
					`SCP_IDX_EXTCLK: begin
						prdata[0] <= ext_en;
					end
					default: begin
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_unlock;
		wr_pre && wb == `SCP_UNLOCK_VAL && ustate == SCP_LOCKED;
	endsequence

	sequence s_select;
		wr_pre && ustate == SCP_OPEN && !wb[7];
	endsequence

	property p_unlock_open;
		s_unlock |=> ustate == SCP_OPEN;
	endproperty
	a_unlock_open: assert property (p_unlock_open) else $error("unlock not opened"); // RL12

	property p_unlock_other;
		wr_pre && wb[7] && wb[6:0] != 7'h00 && ustate == SCP_LOCKED |=> ustate == SCP_LOCKED;
	endproperty
	a_unlock_other: assert property (p_unlock_other) else $error("unlock by bad value"); // RL12

	property p_timeout;
		s_unlock ##1 (!wr_pre)[*4] |=> $past(ustate == SCP_OPEN) && ustate == SCP_LOCKED;
	endproperty
	a_timeout: assert property (p_timeout) else $error("window not four cycles"); // RL13

	property p_no_restart;
		ustate == SCP_OPEN && wr_pre && wb == `SCP_UNLOCK_VAL && ucnt != 3'd0
			|=> ustate == SCP_OPEN && ucnt == $past(ucnt) - 3'd1;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("window restarted"); // RL14

	property p_select_taken;
		s_select and (init_cnt == 2'd3) |=> sel == $past(wb[3:0]) && ustate == SCP_LOCKED;
	endproperty
	a_select_taken: assert property (p_select_taken) else $error("select not taken"); // RL13

	property p_select_locked;
		ustate == SCP_LOCKED && init_cnt == 2'd3 |=> $stable(sel);
	endproperty
	a_select_locked: assert property (p_select_locked) else $error("locked select changed"); // RL13

	property p_switch;
		$rose(pending) |-> ##[1:256] !pending;
	endproperty
	a_switch: assert property (p_switch) else $error("switch too slow"); // RL7

	property p_change_on_edge;
		eff_code != $past(eff_code) |-> $past(tick) && cnt == 8'h00;
	endproperty
	a_change_on_edge: assert property (p_change_on_edge) else $error("glitch on switch"); // RL6

	property p_reserved;
		eff_code > `SCP_CODE_MAX |-> lim == 8'hff;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code factor"); // RL22

	property p_enable;
		// Each domain pulses exactly one cycle after every terminal count, and never otherwise.
		1'b1 |=> {cpu_clock_en, flash_clock_en, io_clock_en} == {3{$past(tick)}};
	endproperty
	a_enable: assert property (p_enable) else $error("enable pulse wrong"); // RL5

	property p_div8;
		init_cnt == 2'd2 |=> sel == ($past(d8f_s2) ? 4'h3 : 4'h0);
	endproperty
	a_div8: assert property (p_div8) else $error("reset select wrong"); // RL15

	property p_clkout;
		cof_s2 |=> clock_out_drive;
	endproperty
	a_clkout: assert property (p_clkout) else $error("clock out not driven"); // RL3

endmodule

// [test/scp_prescaler_tb.sv]
// Self-checking testbench of the system clock prescaler and trim block.
// Assumes scp_prescaler answers APB with zero wait states and that the
// assertions live in the design file, so no separate checker is bound.
`timescale 1ns/1ps
`include "scp_cfg.svh"

module scp_prescaler_tb
	import scp_pkg::*;
;
	logic pclk; // Master clock, 8 ns period.
	logic presetn; // Asynchronous reset, active low.
	logic psel, penable, pwrite; // APB request.
	logic [11:0] paddr; // APB byte address.
	logic [31:0] pwdata, prdata; // APB data.
	logic pready, pslverr; // APB answer.
	logic clock_out_fuse, divide_by_eight_fuse; // Static fuse pins.
	logic [7:0] rc_trim_factory; // Factory trim pins.
	logic cpu_clock_en, flash_clock_en, io_clock_en; // Divided clock pulses.
	logic clock_out_pin, clock_out_drive, ext_clock_input_enable;
	logic trim_range_bit; // Oscillator range bit.
	logic [6:0] trim_tune; // Oscillator tune bits.
	int bad_count = 0; // Mismatches seen.
	int checks = 0; // Comparisons made.
	int seed = 95; // Fixed seed for repeatable random stimulus.
	int sel_m, trim_m; // Model of the select field and trim register.
	int floor_fac = 1; // Shortest legal gap between divided clock pulses.
	int gap = 1; // Cycles since the last divided clock pulse.
	int fz, c, i; // Loop variables of the main sequence.
	logic [31:0] d; // Read data of the unmapped access.
	logic e; // Error flag of the unmapped access.

	scp_prescaler i_scp_prescaler (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clock_out_fuse(clock_out_fuse), .divide_by_eight_fuse(divide_by_eight_fuse),
		.rc_trim_factory(rc_trim_factory), .cpu_clock_en(cpu_clock_en),
		.flash_clock_en(flash_clock_en), .io_clock_en(io_clock_en),
		.clock_out_pin(clock_out_pin), .clock_out_drive(clock_out_drive),
		.ext_clock_input_enable(ext_clock_input_enable),
		.trim_range_bit(trim_range_bit), .trim_tune(trim_tune));

	// ----------------------------------------------------------------
	// Clock, watchdog and shared tasks.
	// ----------------------------------------------------------------
	// Free-running master clock.
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Cuts a hang short; the whole run needs well under 20000 cycles.
	initial begin
		#(8 * 60000);
		bad_count++;
		$display("watchdog expired");
		finish_test();
	end

	// Division factor of a select code; reserved codes run at 256.
	function automatic int fac(input int code);
		return (code > 8) ? 256 : (1 << code);
	endfunction

	// Compares one value and counts the result.
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer, entered just after a rising edge, plus one idle cycle.
	task apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// The request stands until pready is seen at a rising edge; only the
		// watchdog ends a wait that never gets an answer.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Register write.
	task wr(input logic [9:0] idx, input logic [7:0] v);
		logic [31:0] rdat;
		logic rerr;
		apb(1'b1, idx, v, rdat, rerr);
	endtask

	// Register read compared with the model.
	task rd(input logic [9:0] idx, input logic [31:0] exp, input string nm);
		logic [31:0] rdat;
		logic rerr;
		apb(1'b0, idx, 8'h00, rdat, rerr);
		chk(nm, rdat, exp);
		chk("pslverr", {31'h0, rerr}, 32'h0);
	endtask

	// Unlock and select; the glitch floor covers the old and new factor.
	task set_code(input int code);
		floor_fac = (fac(code) < fac(sel_m)) ? fac(code) : fac(sel_m);
		wr(`SCP_IDX_PRESCALE, `SCP_UNLOCK_VAL);
		// Nothing may come between the two writes, as with interrupts masked.
		wr(`SCP_IDX_PRESCALE, code[7:0]);
		sel_m = code;
	endtask

	// Syncs to a pulse, then measures two full periods; the last must be new.
	task meas(input int f);
		int g, hi, k;
		for (k = 0; k < 3; k++) begin
			g = 0;
			hi = 0;
			do begin
				@(posedge pclk);
				g++;
				hi += (clock_out_pin === 1'b1) ? 1 : 0;
			end while (cpu_clock_en !== 1'b1 && g < 600);
		end
		chk("cpu period", g, f);
		chk("flash io pulse", {30'h0, flash_clock_en, io_clock_en}, 32'h3);
		if (f > 1) begin
			chk("clock out high", hi, f / 2);
		end
		floor_fac = f;
	endtask

	// Every gap between divided pulses stays at or above the floor.
	always @(posedge pclk) begin
		if (cpu_clock_en === 1'b1) begin
			chk("pulse gap floor", (gap < floor_fac) ? 1 : 0, 0);
			gap = 1;
		end else begin
			gap++;
		end
	end

	// Verdict, reached from the main sequence or the watchdog.
	task finish_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = 12'h000;
		pwdata = 32'h0;
		{clock_out_fuse, divide_by_eight_fuse} = 2'b00;
		rc_trim_factory = 8'h00;
		// Both fuse settings, each with its own random factory trim.
		for (fz = 1; fz >= 0; fz--) begin
			@(posedge pclk);
			presetn <= 1'b0;
			clock_out_fuse <= fz[0];
			divide_by_eight_fuse <= fz[0];
			rc_trim_factory <= 8'($random(seed));
			floor_fac = 1;
			repeat (20) @(posedge pclk);
			presetn <= 1'b1;
			repeat (4) @(posedge pclk);
			sel_m = fz ? 3 : 0;
			trim_m = rc_trim_factory;
			rd(`SCP_IDX_PRESCALE, sel_m, "reset select");
			rd(`SCP_IDX_TRIM, trim_m, "factory trim");
			chk("clock out drive", {31'h0, clock_out_drive}, fz);
			meas(fac(sel_m));
		end
		// Codes 0 to 9, reserved 9 included, with readback and measured rate.
		for (c = 0; c <= 9; c++) begin
			set_code(c);
			rd(`SCP_IDX_PRESCALE, sel_m, "select readback");
			meas(fac(c));
		end
		// A select write closes the window; the next one is ignored.
		set_code(2);
		wr(`SCP_IDX_PRESCALE, 8'h06);
		rd(`SCP_IDX_PRESCALE, sel_m, "closed by select");
		// Unlock value with a stray bit does not open the window.
		wr(`SCP_IDX_PRESCALE, 8'h81);
		wr(`SCP_IDX_PRESCALE, 8'h05);
		rd(`SCP_IDX_PRESCALE, sel_m, "bad unlock");
		// The window times out before a late select.
		wr(`SCP_IDX_PRESCALE, `SCP_UNLOCK_VAL);
		repeat (3) @(posedge pclk);
		wr(`SCP_IDX_PRESCALE, 8'h05);
		rd(`SCP_IDX_PRESCALE, sel_m, "window timeout");
		// A second unlock does not restart the window.
		wr(`SCP_IDX_PRESCALE, `SCP_UNLOCK_VAL);
		wr(`SCP_IDX_PRESCALE, `SCP_UNLOCK_VAL);
		wr(`SCP_IDX_PRESCALE, 8'h05);
		rd(`SCP_IDX_PRESCALE, sel_m, "no restart");
		meas(fac(sel_m));
		// Trim range boundary values, then random ones; no flash or memory
		// write follows, so any trim value is a legal setting here.
		for (i = 0; i < 6; i++) begin
			trim_m = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : ($random(seed) & 8'hff);
			wr(`SCP_IDX_TRIM, trim_m[7:0]);
			rd(`SCP_IDX_TRIM, trim_m, "trim readback");
			chk("trim outputs", {24'h0, trim_range_bit, trim_tune}, trim_m);
		end
		// External clock input enable set and cleared; no timer clock is
		// applied, so the system clock is never slower than four times it.
		for (i = 1; i >= 0; i--) begin
			wr(`SCP_IDX_EXTCLK, i[7:0]);
			rd(`SCP_IDX_EXTCLK, i, "ext clock reg");
			chk("ext clock pin", {31'h0, ext_clock_input_enable}, i);
		end
		// Unmapped index answers with an error and zero data.
		apb(1'b0, 10'h3ff, 8'h00, d, e);
		chk("unmapped error", {31'h0, e}, 32'h1);
		chk("unmapped data", d, 32'h0);
		finish_test();
	end
endmodule
